// File: verilog/sys_config_consts.vh
`ifndef SYS_CONFIG_CONSTS_VH
`define SYS_CONFIG_CONSTS_VH
// Strap positions in the sampled pins: data bus bits, then the clock and breakpoint straps
`define STRAP_BOOT_WIDTH   0
`define STRAP_CS_LOW       1
`define STRAP_CS_MID       2
`define STRAP_ADDR_FIRST   3
`define STRAP_ADDR_LAST    7
`define STRAP_PORT_E       8
`define STRAP_PORT_F       9
`define STRAP_TEST         11
`define STRAP_CLOCK        16
`define STRAP_BREAK        17
// Register block placement
`define BLOCK_UPPER_LOW    12'h07ff
`define BLOCK_UPPER_HIGH   12'h0fff
`define BLOCK_OFFSET_BITS  12
// Arbitration identifiers
`define ARB_ID_OWN_RESET   4'hf
`define ARB_ID_MOD_RESET   4'h0
`define ARB_ID_WIDTH       4
`endif

// File: verilog/arb_contend.v
`timescale 1ns/1ps
`default_nettype none
// Serial bitwise contention: bit-serial, MSB first, an entrant that drives
// a 0 while the wired bus shows a 1 drops out.
module arb_contend
#(
   parameter N = 4
)
(
   input  wire         i_clk,
   input  wire         i_reset_n,
   input  wire         i_start,
   input  wire [N-1:0] i_req,
   input  wire [4*N-1:0] i_ids,
   output reg          o_done,
   output reg  [N-1:0] o_winner,
   output reg  [3:0]   o_win_id
);
   reg [N-1:0] alive_q;
   reg [1:0]   bit_q;
   reg         busy_q;
   reg         line;
   reg [N-1:0] alive_d;
   integer     k;

   always @*
   begin
      line = 1'b0;
      for (k = 0; k < N; k = k + 1)
         line = line | (alive_q[k] & i_ids[4*k+bit_q]);
      alive_d = alive_q;
      for (k = 0; k < N; k = k + 1)
         if (line && !i_ids[4*k+bit_q])
            alive_d[k] = 1'b0;
   end

   always @(posedge i_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         alive_q  <= {N{1'b0}};
         bit_q    <= 2'd3;
         busy_q   <= 1'b0;
         o_done   <= 1'b0;
         o_winner <= {N{1'b0}};
         o_win_id <= 4'h0;
      end
      else
      begin
         o_done <= 1'b0;
         if (i_start)
         begin
            alive_q <= i_req;
            bit_q   <= 2'd3;
            busy_q  <= 1'b1;
         end
         else if (busy_q)
         begin
            alive_q           <= alive_d;
            o_win_id[bit_q]   <= line;
            bit_q             <= bit_q - 2'd1;
            if (bit_q == 2'd0)
            begin
               busy_q   <= 1'b0;
               o_done   <= 1'b1;
               o_winner <= alive_d;
            end
         end
      end
   end
endmodule
`default_nettype wire

// File: verilog/reset_config.v
`include "sys_config_consts.vh"
//
// Operation
// - Data pin 0 high at reset gives 16-bit boot select, low 8-bit.
// - Pin 1 picks selects 0-2 or arbitration; pin 2 selects 3-5 or codes.
// - The highest low pin of 3..7 swaps upper selects for address 19 up to its own line (19..23).
// - Clock mode pin high picks synthesizer, low picks external reference.
// - Breakpoint pin high at reset disables background debug, low enables.
// - Other modules' pins start in their port function after reset.
// - All port direction registers clear to input after reset.
// - All module control registers decode inside one 4-Kbyte block.
// - Mapping bit 0 places the block at 7FF000 through 7FFFFF.
// - Mapping bit 1 places the block at FFF000 through FFFFFF.
// - Unused block addresses go external; reserved sub-blocks never do.
// - Some internal registers are reachable only from supervisor space.
// - Each requesting module holds an ID; equal priorities contend bitwise.
// - Contention runs on every acknowledge, even with one request.
// - Only non-zero ID wins service; ID zero gives spurious exception.
// - Integration unit contends with its own ID for external requests.
// - On reset own ID is 1111 and all module IDs are 0000.
// - Read-only flag is set when the test strap is sampled low.
//
`timescale 1ns/1ps
`default_nettype none
module reset_config
#(
   parameter NMOD = 3
)
(
   input  wire              i_clk,
   input  wire              i_reset_n,
   input  wire [15:0]       i_data_pins,
   input  wire              i_clock_source_strap,
   input  wire              i_breakpoint_pin,
   input  wire              i_block_map_select,
   input  wire [3:0]        i_own_id_wr_data,
   input  wire              i_own_id_wr,
   input  wire [4*NMOD-1:0] i_mod_id_wr_data,
   input  wire [NMOD-1:0]   i_mod_id_wr,
   input  wire              i_acc_valid,
   input  wire [23:0]       i_acc_addr,
   input  wire              i_acc_super,
   input  wire              i_acc_reserved,
   input  wire              i_acc_mapped,
   input  wire              i_acc_protected,
   input  wire              i_iack,
   input  wire              i_ext_irq,
   input  wire [NMOD-1:0]   i_mod_irq,
   output reg               o_boot_chip_select_16,
   output reg  [2:0]        o_cs_low_enable,
   output reg  [2:0]        o_cs_mid_enable,
   output reg  [4:0]        o_addr_hi_enable,
   output reg               o_gp_port_e,
   output reg               o_gp_port_f,
   output reg               o_slave_test_flag,
   output reg               o_clock_from_synth,
   output reg               o_bdm_enable,
   output reg               o_module_pin_func,
   output reg               o_port_dir_out,
   output reg               o_acc_internal,
   output reg               o_acc_external,
   output reg               o_acc_fault,
   output reg  [3:0]        o_arbitration_id,
   output reg               o_iack_done,
   output reg               o_iack_ext,
   output reg  [NMOD-1:0]   o_iack_mod,
   output reg               o_spurious
);
   // -------------------------------------------------------------------
   // Strap sampling
   // -------------------------------------------------------------------
   // Straps count only while reset is held, so the sampling chain and the
   // strap latch carry no reset: an asynchronous reset would pin them to a
   // constant in exactly the cycles in which the pins matter. The latch
   // follows agreeing stages and freezes at the third edge after release,
   // before the core starts to drive the shared data pins.
   reg [17:0] s1_q;
   reg [17:0] s2_q;
   reg [17:0] s3_q;
   reg [17:0] strap_q;
   reg        rst1_q;
   reg        rst2_q;
   reg        run_q;
   wire [17:0] pins = {i_breakpoint_pin, i_clock_source_strap, i_data_pins};

   // Pins are asynchronous to i_clk: three flops, the first read only once
   always @(posedge i_clk)
   begin
      s1_q <= pins;
      s2_q <= s1_q;
      s3_q <= s2_q;
   end

   // Release stages: run_q rises at the third edge after reset goes high
   always @(posedge i_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         rst1_q <= 1'b0;
         rst2_q <= 1'b0;
         run_q  <= 1'b0;
      end
      else
      begin
         rst1_q <= 1'b1;
         rst2_q <= rst1_q;
         run_q  <= rst2_q;
      end
   end

   // A pin still settling is never taken: stages two and three must agree
   always @(posedge i_clk)
   begin
      if (!run_q && (s2_q == s3_q))
         strap_q <= s3_q;
   end

   // -------------------------------------------------------------------
   // Pin configuration
   // -------------------------------------------------------------------
   function [4:0] addr_mask;
      input [4:0] low_pins;
      integer j;
      reg     on;
      begin
         on = 1'b0;
         addr_mask = 5'h0;
         for (j = 4; j >= 0; j = j - 1)
         begin
            on = on | low_pins[j];
            addr_mask[j] = on;
         end
      end
   endfunction

   always @(posedge i_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         o_boot_chip_select_16 <= 1'b1;
         o_cs_low_enable       <= 3'h7;
         o_cs_mid_enable       <= 3'h7;
         o_addr_hi_enable      <= 5'h0;
         o_gp_port_e           <= 1'b0;
         o_gp_port_f           <= 1'b0;
         o_slave_test_flag     <= 1'b0;
      end
      else
      begin
         o_boot_chip_select_16 <= strap_q[`STRAP_BOOT_WIDTH];
         o_cs_low_enable <= {3{strap_q[`STRAP_CS_LOW]}};
         o_cs_mid_enable <= {3{strap_q[`STRAP_CS_MID]}};
         // Pin 7 low implies all five lines, pin 3 low only line 19
         o_addr_hi_enable <= addr_mask(
            ~strap_q[`STRAP_ADDR_LAST:`STRAP_ADDR_FIRST]);
         o_gp_port_e <= ~strap_q[`STRAP_PORT_E];
         o_gp_port_f <= ~strap_q[`STRAP_PORT_F];
         o_slave_test_flag <= ~strap_q[`STRAP_TEST];
      end
   end

   // -------------------------------------------------------------------
   // Clock, debug and module pin defaults
   // -------------------------------------------------------------------
   // Module pins leave reset as port inputs; clock and debug choices stay
   // fixed by the straps until the next reset, whatever the core writes.
   always @(posedge i_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         o_clock_from_synth    <= 1'b1;
         o_bdm_enable          <= 1'b0;
         o_module_pin_func     <= 1'b0;
         o_port_dir_out        <= 1'b0;
      end
      else
      begin
         o_clock_from_synth <= strap_q[`STRAP_CLOCK];
         o_bdm_enable <= ~strap_q[`STRAP_BREAK];
         o_module_pin_func <= 1'b0;
         o_port_dir_out <= 1'b0;
      end
   end

   // -------------------------------------------------------------------
   // Register block decode
   // -------------------------------------------------------------------
   // Upper address bits of the block: the mapping bit, then all ones
   function block_hit;
      input [11:0] upper_bits;
      input        map_high;
      begin
         if (map_high)
            block_hit = (upper_bits == `BLOCK_UPPER_HIGH);
         else
            block_hit = (upper_bits == `BLOCK_UPPER_LOW);
      end
   endfunction

   wire [11:0] upper    = i_acc_addr[23:`BLOCK_OFFSET_BITS];
   // One 4-Kbyte window holds the registers of every module
   wire        in_block = block_hit(upper, i_block_map_select);
   // Reserved sub-blocks fault rather than go out, so that no external
   // device can answer for a register that does not exist.

   always @(posedge i_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         o_acc_internal <= 1'b0;
         o_acc_external <= 1'b0;
         o_acc_fault    <= 1'b0;
      end
      else
      begin
         o_acc_internal <= 1'b0;
         o_acc_external <= 1'b0;
         o_acc_fault    <= 1'b0;
         if (!i_acc_valid)
            o_acc_internal <= 1'b0;
         else if (!in_block)
            o_acc_external <= 1'b1;
         else if (i_acc_reserved)
            o_acc_fault <= 1'b1;
         else if (!i_acc_mapped)
            o_acc_external <= 1'b1;
         else if (i_acc_protected && !i_acc_super)
            o_acc_fault <= 1'b1;
         else
            o_acc_internal <= 1'b1;
      end
   end

   // -------------------------------------------------------------------
   // Interrupt arbitration
   // -------------------------------------------------------------------
   reg [4*NMOD-1:0] mod_id_q;
   integer m;

   always @(posedge i_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         o_arbitration_id <= `ARB_ID_OWN_RESET;
         mod_id_q <= {NMOD{`ARB_ID_MOD_RESET}};
      end
      else
      begin
         if (i_own_id_wr)
            o_arbitration_id <= i_own_id_wr_data;
         for (m = 0; m < NMOD; m = m + 1)
            if (i_mod_id_wr[m])
               mod_id_q[4*m +: 4] <= i_mod_id_wr_data[4*m +: 4];
      end
   end

   wire [NMOD:0]     winner;
   wire              arb_done;
   wire [3:0]        win_id;

   // Own entry sits at index NMOD and stands in for external requests
   // A new acknowledge restarts contention; the result follows five edges on
   arb_contend #(.N(NMOD+1)) u_arb
   (
      .i_clk     (i_clk),
      .i_reset_n (i_reset_n),
      .i_start   (i_iack),
      .i_req     ({i_ext_irq, i_mod_irq}),
      .i_ids     ({o_arbitration_id, mod_id_q}),
      .o_done    (arb_done),
      .o_winner  (winner),
      .o_win_id  (win_id)
   );

   // Entrants that share the winning ID all stay set: no tie is broken here
   always @(posedge i_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         o_iack_done <= 1'b0;
         o_iack_ext  <= 1'b0;
         o_iack_mod  <= {NMOD{1'b0}};
         o_spurious  <= 1'b0;
      end
      else
      begin
         o_iack_done <= arb_done;
         o_iack_ext  <= 1'b0;
         o_iack_mod  <= {NMOD{1'b0}};
         o_spurious  <= 1'b0;
         if (arb_done)
         begin
            if (win_id == 4'h0)
               o_spurious <= 1'b1;
            else
            begin
               o_iack_ext <= winner[NMOD];
               o_iack_mod <= winner[NMOD-1:0];
            end
         end
      end
   end
endmodule
`default_nettype wire

// File: tb/strap_pins.sv
`timescale 1ns/1ps
`default_nettype none
// Strap resistors share the pins with the core's bus. They hold the pins
// only while reset is low and for HOLD cycles after. After that the core
// owns the bus, so the pins toggle every cycle and a late sample shows.
module strap_pins
#(
   parameter HOLD = 4
)
(
   input  wire logic        i_clk,
   input  wire logic        i_reset_n,
   input  wire logic [17:0] i_strap,
   output var  logic [17:0] o_pins
);
   integer n_q;
   always @(posedge i_clk or negedge i_reset_n)
      if (!i_reset_n)
      begin
         n_q <= 0;
         o_pins <= i_strap;
      end
      else if (n_q < HOLD)
      begin
         n_q <= n_q + 1;
         o_pins <= i_strap;
      end
      else
         o_pins <= ~o_pins;
endmodule
`default_nettype wire

// File: tb/reset_config_chk.sv
`timescale 1ns/1ps
`default_nettype none
module reset_config_chk
#(
   parameter NMOD = 3
)
(
   input wire logic            i_clk, i_reset_n, i_block_map_select,
   input wire logic            i_acc_valid, i_acc_super, i_acc_reserved,
   input wire logic            i_acc_mapped, i_acc_protected, i_iack,
   input wire logic [23:0]     i_acc_addr,
   input wire logic [2:0]      o_cs_low_enable,
   input wire logic [4:0]      o_addr_hi_enable,
   input wire logic [3:0]      o_arbitration_id,
   input wire logic [NMOD-1:0] o_iack_mod,
   input wire logic            o_boot_chip_select_16, o_bdm_enable,
   input wire logic            o_module_pin_func, o_port_dir_out,
   input wire logic            o_acc_internal, o_acc_external, o_acc_fault,
   input wire logic            o_iack_done, o_spurious
);
   logic [2:0] up_q;
   logic       blk;
   logic       acc;
   assign blk = i_acc_addr[23:12] == {i_block_map_select, 11'h7ff};
   assign acc = i_acc_valid && blk && !i_acc_reserved && i_acc_mapped;
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (!i_reset_n);
   // Cycles since release; saturates well after the straps freeze
   always @(posedge i_clk or negedge i_reset_n)
      if (!i_reset_n)
         up_q <= 3'h0;
      else if (up_q != 3'h7)
         up_q <= up_q + 3'h1;
   a_strap_frozen:
   assert property (up_q == 3'h7 |-> $stable({o_boot_chip_select_16,
      o_cs_low_enable, o_addr_hi_enable, o_bdm_enable}))
      else $error("configuration moved after strap freeze");
   a_addr_thermo:
   assert property (((o_addr_hi_enable + 5'h01) & o_addr_hi_enable) == 5'h00)
      else $error("address line enables not contiguous");
   a_port_default:
   assert property (!o_module_pin_func && !o_port_dir_out)
      else $error("module pins not in input port function");
   a_acc_outside:
   assert property (i_acc_valid && !blk |=> o_acc_external)
      else $error("access outside block not sent external");
   a_acc_reserved:
   assert property (i_acc_valid && blk && i_acc_reserved |=> o_acc_fault)
      else $error("reserved access not faulted");
   a_acc_unmapped:
   assert property (i_acc_valid && blk && !i_acc_reserved && !i_acc_mapped
      |=> o_acc_external) else $error("unused address not sent external");
   a_acc_user:
   assert property (acc && i_acc_protected && !i_acc_super |=> o_acc_fault)
      else $error("user access to protected register allowed");
   a_acc_inside:
   assert property (acc && (i_acc_super || !i_acc_protected)
      |=> o_acc_internal && !o_acc_external && !o_acc_fault)
      else $error("block access not decoded internally");
   a_iack_latency:
   assert property ($rose(i_iack) |-> ##[5:7] o_iack_done)
      else $error("acknowledge without contention result");
   a_id_reset:
   assert property ($rose(i_reset_n) |-> o_arbitration_id == 4'hf)
      else $error("own arbitration id wrong after reset");
   a_spur_done:
   assert property (o_spurious |-> o_iack_done)
      else $error("spurious flag outside acknowledge result");
   cover property (o_spurious);
   cover property (o_acc_fault);
   cover property (o_iack_done && |o_iack_mod);
endmodule
bind reset_config reset_config_chk #(.NMOD(NMOD)) u_chk (.*);
`default_nettype wire

// File: tb/test_reset_config.sv
`timescale 1ns/1ps
`default_nettype none
module test_reset_config;
   logic i_clk = 1'b0, i_reset_n = 1'b0, i_block_map_select = 1'b0;
   logic i_own_id_wr = 1'b0, i_acc_valid = 1'b0, i_acc_super = 1'b0;
   logic i_acc_reserved = 1'b0, i_acc_mapped = 1'b0, i_iack = 1'b0;
   logic i_acc_protected = 1'b0, i_ext_irq = 1'b0;
   logic [3:0]  i_own_id_wr_data = 4'h0;
   logic [11:0] i_mod_id_wr_data = 12'h000;
   logic [2:0]  i_mod_id_wr = 3'h0, i_mod_irq = 3'h0, x;
   logic [23:0] i_acc_addr = 24'h00_0000;
   logic [17:0] strap = 18'h3_ffff;
   logic [31:0] r;
   logic [3:0]  ids [0:3];
   logic [3:0]  wins;
   logic [4:0]  e;
   wire  [15:0] i_data_pins;
   wire         i_clock_source_strap, i_breakpoint_pin;
   wire  [2:0]  o_cs_low_enable, o_cs_mid_enable, o_iack_mod;
   wire  [4:0]  o_addr_hi_enable;
   wire  [3:0]  o_arbitration_id;
   wire o_boot_chip_select_16, o_gp_port_e, o_gp_port_f, o_slave_test_flag;
   wire o_clock_from_synth, o_bdm_enable, o_module_pin_func, o_port_dir_out;
   wire o_acc_internal, o_acc_external, o_acc_fault, o_iack_done;
   wire o_iack_ext, o_spurious;
   wire [2:0] acc_seen = {o_acc_internal, o_acc_external, o_acc_fault};
   integer err_count = 0, total_checks = 0, seed = 73, k, m, n, best;
   strap_pins #(.HOLD(4)) u_pins (.i_clk(i_clk), .i_reset_n(i_reset_n),
      .i_strap(strap),
      .o_pins({i_breakpoint_pin, i_clock_source_strap, i_data_pins}));
   reset_config #(.NMOD(3)) dut (.*);
   always #2 i_clk = ~i_clk;
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         err_count++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task end_sim;
      $display("checks=%0d errors=%0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   // ------------------------------------------------------------
   // Strapped reset: pins held low-to-high, then checked once frozen
   // ------------------------------------------------------------
   task do_reset(input logic [17:0] s);
      strap = s;
      i_reset_n = 1'b0;
      repeat (3) @(negedge i_clk);
      i_reset_n = 1'b1;
      repeat (7) @(negedge i_clk);
      e = 5'h00;
      for (k = 3; k < 8; k++)
         if (!s[k])
            e = 5'h1f >> (7 - k);
      chk(o_boot_chip_select_16, s[0]);
      chk(o_cs_low_enable, {3{s[1]}});
      chk(o_cs_mid_enable, {3{s[2]}});
      chk(o_addr_hi_enable, e);
      chk(o_clock_from_synth, s[16]);
      chk(o_bdm_enable, !s[17]);
      chk({o_gp_port_e, o_gp_port_f}, {!s[8], !s[9]});
      chk(o_slave_test_flag, !s[11]);
      chk({o_module_pin_func, o_port_dir_out}, 0);
      chk(o_arbitration_id, 4'hf);
   endtask
   task do_iack;
      best = 0;
      for (k = 0; k < 4; k++)
         if ({i_mod_irq, i_ext_irq} >> k & 1 && ids[k] > best)
            best = ids[k];
      for (k = 0; k < 4; k++)
         wins[k] = ({i_mod_irq, i_ext_irq} >> k & 1) && ids[k] == best;
      i_iack = 1'b1;
      @(negedge i_clk);
      i_iack = 1'b0;
      n = 0;
      while (o_iack_done !== 1'b1 && n < 20)
      begin
         @(negedge i_clk);
         n++;
      end
      chk(o_iack_done, 1);
      chk(o_spurious, best == 0);
      if (best != 0)
         chk({o_iack_mod, o_iack_ext}, wins);
      else
         chk({o_iack_mod, o_iack_ext}, 0);
      @(negedge i_clk);
   endtask
   initial
   begin
      #20000;
      err_count++;
      end_sim;
   end
   initial
   begin
      do_reset(18'h3_ffff);
      for (m = 0; m < 6; m++)
      begin
         r = $random(seed);
         do_reset(m == 5 ? 18'h0_0000 : r[17:0]);
      end
      repeat (40)
      begin
         r = $random(seed);
         {i_acc_protected, i_acc_mapped, i_acc_reserved, i_acc_super,
          i_block_map_select} = r[4:0];
         i_acc_addr = {r[5] ? {r[6], 11'h7ff} : r[17:6], r[29:18]};
         i_acc_valid = 1'b1;
         @(negedge i_clk);
         if (i_acc_addr[23:12] != {r[0], 11'h7ff} || (!r[2] && !r[3]))
            x = 3'h2;
         else if (r[2] || (r[4] && !r[1]))
            x = 3'h1;
         else
            x = 3'h4;
         chk(acc_seen, x);
         i_acc_valid = 1'b0;
         @(negedge i_clk);
      end
      for (k = 0; k < 4; k++)
         ids[k] = k == 0 ? 4'hf : 4'h0;
      i_mod_irq = 3'h7;
      do_iack;
      i_ext_irq = 1'b1;
      do_iack;
      repeat (12)
      begin
         r = $random(seed);
         {i_mod_id_wr_data, i_own_id_wr_data} = r[15:0];
         {ids[3], ids[2], ids[1], ids[0]} = r[15:0];
         i_own_id_wr = 1'b1;
         i_mod_id_wr = 3'h7;
         @(negedge i_clk);
         i_own_id_wr = 1'b0;
         i_mod_id_wr = 3'h0;
         {i_mod_irq, i_ext_irq} = r[19:16];
         @(negedge i_clk);
         chk(o_arbitration_id, ids[0]);
         do_iack;
      end
      end_sim;
   end
endmodule
`default_nettype wire
